// *** src/scc_pkg.sv ***
// Shared constants, types and address decoders for the secondary cache controller.
// Assumes a 32-bit processor bus with word address bits 31..2 and 16-byte lines.
package scc_pkg;

    // Geometry of the smaller module size (128 KB, 16-byte lines, direct mapped)
    localparam int SCC_WORD_LSB = 2;
    localparam int SCC_WORD_W = 2;
    localparam int SCC_INDEX_LSB = 4;
    localparam int SCC_INDEX_W = 13;
    localparam int SCC_TAG_LSB = 17;
    localparam int SCC_TAG_W = 15;
    localparam int SCC_LINES = 8192;
    localparam int SCC_DADDR_W = SCC_INDEX_W + SCC_WORD_W;
    localparam int SCC_WORDS = 32768;
    localparam int SCC_LANES = 4;
    localparam int SCC_LANE_W = 8;

    // Size identifier codes driven on the two id pins
    localparam logic [1:0] SCC_ID_128K = 2'h3;
    localparam logic [1:0] SCC_ID_256K = 2'h2;
    localparam logic [1:0] SCC_ID_512K = 2'h1;
    localparam logic [1:0] SCC_ID_1M = 2'h0;
    localparam logic [1:0] SCC_ID_THIS = SCC_ID_128K;

    // Byte enable pattern (lanes 3..0, active low) of the flush special cycle
    localparam logic [3:0] SCC_FLUSH_BE_N = 4'hD;

    // Line fill word counts: third transfer samples protect, fourth ends the fill
    localparam logic [1:0] SCC_WP_WORD = 2'h2;
    localparam logic [1:0] SCC_LAST_WORD = 2'h3;
    localparam logic [1:0] SCC_FIRST_WORD = 2'h0;
    localparam logic [1:0] SCC_WORD_STEP = 2'h1;

    // Address latch hold times after a cycle start and after an invalidation
    localparam logic [1:0] SCC_HOLD_START = 2'h1;
    localparam logic [1:0] SCC_HOLD_INVAL = 2'h2;
    localparam logic [1:0] SCC_HOLD_NONE = 2'h0;

    // Control sequencer states
    typedef enum logic [1:0] {
        SCC_IDLE = 2'b00,
        SCC_RD_HIT = 2'b01,
        SCC_RD_MISS = 2'b10,
        SCC_WRITE = 2'b11
    } scc_state_t;

    // Line index of a word address
    function automatic logic [SCC_INDEX_W-1:0] scc_index(input logic [31:2] a);
        scc_index = a[SCC_INDEX_LSB +: SCC_INDEX_W];
    endfunction

    // Tag of a word address
    function automatic logic [SCC_TAG_W-1:0] scc_tag(input logic [31:2] a);
        scc_tag = a[SCC_TAG_LSB +: SCC_TAG_W];
    endfunction

    // Word within the line of a word address
    function automatic logic [SCC_WORD_W-1:0] scc_word(input logic [31:2] a);
        scc_word = a[SCC_WORD_LSB +: SCC_WORD_W];
    endfunction

endpackage

// *** src/scc_array_if.sv ***
// Connection between the cache sequencer and its tag and data stores.
// Assumes all three sit on the same clock; every store read is combinational.
`timescale 1ns/100ps
interface scc_array_if;
    import scc_pkg::*;

    logic [SCC_INDEX_W-1:0] lk_index; // Lookup line index
    logic [SCC_TAG_W-1:0] lk_tag; // Lookup tag
    logic lk_hit; // Tag match with valid bit set
    logic [SCC_INDEX_W-1:0] upd_index; // Fill line index
    logic [SCC_TAG_W-1:0] upd_tag; // Fill tag
    logic fill_clear; // Invalidate line and store new tag
    logic fill_valid; // Mark filled line valid
    logic snoop_en; // Invalidate line if tag matches
    logic [SCC_INDEX_W-1:0] snoop_index;
    logic [SCC_TAG_W-1:0] snoop_tag;
    logic flush_all; // Clear every valid bit
    logic [SCC_DADDR_W-1:0] rd_addr; // Data read word address
    logic [31:0] rd_data;
    logic [3:0] rd_par;
    logic [SCC_DADDR_W-1:0] wr_addr; // Data write word address
    logic [3:0] wr_lane; // Lanes to write, active high
    logic [31:0] wr_data;
    logic [3:0] wr_par;

    modport ctl (
        output lk_index, lk_tag, upd_index, upd_tag, fill_clear, fill_valid,
        output snoop_en, snoop_index, snoop_tag, flush_all,
        output rd_addr, wr_addr, wr_lane, wr_data, wr_par,
        input lk_hit, rd_data, rd_par
    );
    modport tags (
        input lk_index, lk_tag, upd_index, upd_tag, fill_clear, fill_valid,
        input snoop_en, snoop_index, snoop_tag, flush_all,
        output lk_hit
    );
    modport data (
        input rd_addr, wr_addr, wr_lane, wr_data, wr_par,
        output rd_data, rd_par
    );
endinterface

// *** src/scc_tag_store.sv ***
// Tag and valid storage, one entry per line, with whole-cache flush.
// Assumes at most one fill update and one snoop update per cycle.
`timescale 1ns/100ps
module scc_tag_store
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    scc_array_if.tags arr
);

    logic [SCC_LINES-1:0] valid_q; // One valid bit per line
    logic [SCC_TAG_W-1:0] tag_q [SCC_LINES]; // Stored tags, not reset

    // Hit needs both a tag match and a set valid bit
    assign arr.lk_hit = valid_q[arr.lk_index] && (tag_q[arr.lk_index] == arr.lk_tag);

    // Valid bits: flush beats everything, snoop clear beats a fill on the same line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= '0;
        end else if (ce) begin
            if (arr.flush_all) begin
                valid_q <= '0;
            end else begin
                if (arr.fill_clear) begin
                    valid_q[arr.upd_index] <= 1'b0;
                end
                if (arr.fill_valid) begin
                    valid_q[arr.upd_index] <= 1'b1;
                end
                // Snoop last so a racing fill cannot resurrect the line
                if (arr.snoop_en && tag_q[arr.snoop_index] == arr.snoop_tag) begin
                    valid_q[arr.snoop_index] <= 1'b0;
                end
            end
        end
    end

    // Tags are written when a fill starts; no reset since valid guards them
    always_ff @(posedge clk) begin
        if (ce && arr.fill_clear) begin
            tag_q[arr.upd_index] <= arr.upd_tag;
        end
    end

endmodule

// *** src/scc_data_store.sv ***
// Data and parity storage, one 36-bit word per location, byte-lane writes.
// Assumes the sequencer registers the read data before it reaches a pin.
`timescale 1ns/100ps
module scc_data_store
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic ce,
    scc_array_if.data arr
);

    logic [SCC_LANE_W:0] mem_q [SCC_LANES][SCC_WORDS]; // Parity bit on top of each byte

    // Each lane is an independent byte plus parity
    for (genvar l = 0; l < SCC_LANES; l++) begin : g_lane
        always_ff @(posedge clk) begin
            if (ce && arr.wr_lane[l]) begin
                mem_q[l][arr.wr_addr] <= {arr.wr_par[l], arr.wr_data[l*SCC_LANE_W +: SCC_LANE_W]};
            end
        end
        assign arr.rd_data[l*SCC_LANE_W +: SCC_LANE_W] = mem_q[l][arr.rd_addr][SCC_LANE_W-1:0];
        assign arr.rd_par[l] = mem_q[l][arr.rd_addr][SCC_LANE_W];
    end

endmodule

// *** src/scc_cache_ctrl.sv ***
// Control logic of a direct-mapped write-through secondary cache on a processor bus.
// Assumes every bus input is driven on clk by the processor or memory controller.
`timescale 1ns/100ps

module scc_cache_ctrl
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cache_reset,
    input wire logic cycle_start_strobe_n,
    input wire logic snoop_address_strobe_n,
    input wire logic chip_select_n,
    input wire logic mem_io,
    input wire logic write_read,
    input wire logic data_control,
    input wire logic [3:0] byte_lane_enable_n,
    input wire logic [31:2] cpu_addr,
    input wire logic [31:0] data_in,
    input wire logic [3:0] byte_parity_in,
    input wire logic mem_burst_ready_in_n,
    input wire logic mem_single_ready_in_n,
    input wire logic burst_final_n,
    input wire logic bus_backoff_n,
    input wire logic system_cacheable_n,
    input wire logic write_protect,
    input wire logic flush_n,
    input wire logic protect_strap_unused,
    output logic mem_start_n,
    output logic cache_burst_ready_out_n,
    output logic cacheable_to_cpu_n,
    output logic [31:0] data_out,
    output logic [3:0] byte_parity_out,
    output logic data_oe_n,
    output logic module_present_n,
    output logic size_id_bit0,
    output logic size_id_bit1
);

    scc_array_if arr ();

    scc_state_t state_q; // Sequencer state
    logic [31:2] addr_q; // Address latched at cycle start
    logic [SCC_WORD_W-1:0] cnt_q; // Words presented or received so far
    logic [3:0] be_n_q; // Byte enables latched at a write start
    logic hit_q; // Lookup result latched at a write start
    logic fill_ok_q; // Line still cacheable during a fill
    logic fill_started_q; // First fill word already received
    logic system_cacheable_n_seen_q; // System cacheable seen before the first word
    logic system_cacheable_n_prev_q; // System cacheable sampled in the previous cycle
    logic wp_q; // Line flagged write protected on the third word
    logic [1:0] hold_q; // Cycles the address latch stays busy
    logic snoop_pend_q; // Invalidation waiting for its lookup
    logic [31:2] snoop_addr_q; // Latched invalidation address
    logic mem_start_q;
    logic brdy_q;
    logic cacheable_to_cpu_n_q;
    logic [31:0] dout_q;
    logic [3:0] pout_q;
    logic oe_n_q;
    logic present_q;
    logic [1:0] id_q;

    // Decoded bus requests
    logic sel; // Module selected
    logic ready; // Memory returned a word this cycle
    logic snoop_raw; // Invalidation strobe with select
    logic snoop_take; // Invalidation accepted
    logic start_take; // Cycle start accepted
    logic mem_cyc; // Accepted memory cycle
    logic flush_cyc; // Accepted flush special cycle
    logic backoff; // Backoff asserted
    logic fill_word; // Fill word taken this cycle
    logic fill_last; // Last word of a fill
    logic fill_end; // Fill ends this cycle, complete or aborted
    logic fill_cacheable; // Cacheability valid at the current fill word

    assign sel = !chip_select_n;
    assign backoff = !bus_backoff_n;
    assign ready = !mem_burst_ready_in_n || !mem_single_ready_in_n;
    assign snoop_raw = !snoop_address_strobe_n && sel;
    // A busy address latch drops the invalidation
    assign snoop_take = snoop_raw && (hold_q == SCC_HOLD_NONE);
    // Snoop has priority, backoff blocks starts, only an idle sequencer starts
    assign start_take = !cycle_start_strobe_n && sel && !snoop_raw && !backoff
                        && state_q == SCC_IDLE;
    // I/O cycles never look up nor fill
    assign mem_cyc = start_take && mem_io;
    assign flush_cyc = start_take && !data_control && !mem_io && write_read
                       && byte_lane_enable_n == SCC_FLUSH_BE_N;
    assign fill_word = state_q == SCC_RD_MISS && ready && !backoff;
    assign fill_last = cnt_q == SCC_LAST_WORD;
    // Burst last before the fourth word aborts the fill
    assign fill_end = fill_word && (fill_last || !burst_final_n);
    // At the first word only an earlier cacheable sample counts
    assign fill_cacheable = fill_started_q ? fill_ok_q : system_cacheable_n_seen_q;

    // Store requests
    always_comb begin
        arr.lk_index = scc_index(cpu_addr);
        arr.lk_tag = scc_tag(cpu_addr);
        arr.upd_index = scc_index(addr_q);
        arr.upd_tag = scc_tag(addr_q);
        arr.snoop_index = scc_index(snoop_addr_q);
        arr.snoop_tag = scc_tag(snoop_addr_q);
        arr.snoop_en = snoop_pend_q;
        // Reset pin, flush pin and flush cycle all wipe the valid bits
        arr.flush_all = cache_reset || !flush_n || flush_cyc;
        // Line invalidated and retagged on the first cacheable word
        arr.fill_clear = fill_word && !fill_started_q && system_cacheable_n_seen_q;
        // Validation needs cacheable start, no protect, cacheable before last word
        arr.fill_valid = 1'b0;
        if (fill_word && fill_last && fill_ok_q && !wp_q && system_cacheable_n_prev_q) begin
            arr.fill_valid = 1'b1;
        end
        // First word comes from the pins, later words follow the burst order
        if (state_q == SCC_IDLE) begin
            arr.rd_addr = {scc_index(cpu_addr), scc_word(cpu_addr)};
        end else begin
            arr.rd_addr = {scc_index(addr_q), scc_word(addr_q) ^ (cnt_q + SCC_WORD_STEP)};
        end
        arr.wr_data = data_in;
        arr.wr_par = byte_parity_in;
        if (state_q == SCC_RD_MISS) begin
            arr.wr_addr = {scc_index(addr_q), scc_word(addr_q) ^ cnt_q};
            arr.wr_lane = (fill_word && fill_cacheable) ? 4'hF : 4'h0;
        end else begin
            // Write hits update only the enabled bytes, address still on the pins
            arr.wr_addr = {scc_index(cpu_addr), scc_word(cpu_addr)};
            arr.wr_lane = (state_q == SCC_WRITE && ready && hit_q && arr.lk_hit && !backoff)
                          ? ~be_n_q : 4'h0;
        end
    end

    scc_tag_store u_tags (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .arr(arr.tags)
    );

    scc_data_store u_data (
        .clk(clk),
        .ce(ce),
        .arr(arr.data)
    );

    // Sequencer: backoff and the reset pin both drop any cycle in progress
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SCC_IDLE;
        end else if (ce) begin
            if (cache_reset || backoff) begin
                state_q <= SCC_IDLE;
            end else begin
                case (state_q)
                    SCC_IDLE: begin
                        if (mem_cyc && write_read) begin
                            state_q <= SCC_WRITE;
                        end else if (mem_cyc && arr.lk_hit) begin
                            state_q <= SCC_RD_HIT;
                        end else if (mem_cyc) begin
                            state_q <= SCC_RD_MISS;
                        end
                    end
                    SCC_RD_HIT: begin
                        if (!burst_final_n) begin
                            state_q <= SCC_IDLE;
                        end
                    end
                    SCC_RD_MISS: begin
                        if (fill_end) begin
                            state_q <= SCC_IDLE;
                        end
                    end
                    SCC_WRITE: begin
                        if (ready) begin
                            state_q <= SCC_IDLE;
                        end
                    end
                    default: begin
                        state_q <= SCC_IDLE;
                    end
                endcase
            end
        end
    end

    // Cycle context latched at the start and word counting
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            be_n_q <= 4'hF;
            hit_q <= 1'b0;
            cnt_q <= SCC_FIRST_WORD;
        end else if (ce) begin
            if (mem_cyc) begin
                addr_q <= cpu_addr;
                cnt_q <= SCC_FIRST_WORD;
                hit_q <= arr.lk_hit;
                // Byte enables matter only for writes
                be_n_q <= write_read ? byte_lane_enable_n : 4'hF;
            end else if (fill_word || (state_q == SCC_RD_HIT && burst_final_n)) begin
                cnt_q <= cnt_q + SCC_WORD_STEP;
            end
        end
    end

    // Fill cacheability tracking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_ok_q <= 1'b0;
            fill_started_q <= 1'b0;
            system_cacheable_n_seen_q <= 1'b0;
            system_cacheable_n_prev_q <= 1'b0;
            wp_q <= 1'b0;
        end else if (ce) begin
            system_cacheable_n_prev_q <= !system_cacheable_n;
            if (mem_cyc) begin
                fill_ok_q <= 1'b0;
                fill_started_q <= 1'b0;
                system_cacheable_n_seen_q <= 1'b0;
                wp_q <= 1'b0;
            end else if (state_q == SCC_RD_MISS) begin
                // Cacheable only if seen strictly before the first word
                if (!fill_started_q && !ready && !system_cacheable_n) begin
                    system_cacheable_n_seen_q <= 1'b1;
                end
                if (fill_word) begin
                    fill_started_q <= 1'b1;
                    fill_ok_q <= fill_cacheable;
                end
                if (fill_word && cnt_q == SCC_WP_WORD && write_protect) begin
                    wp_q <= 1'b1;
                end
            end
        end
    end

    // Address latch busy time and pending invalidation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= SCC_HOLD_NONE;
            snoop_pend_q <= 1'b0;
            snoop_addr_q <= '0;
        end else if (ce) begin
            snoop_pend_q <= snoop_take;
            if (snoop_take) begin
                snoop_addr_q <= cpu_addr;
                hold_q <= SCC_HOLD_INVAL;
            end else if (start_take) begin
                hold_q <= SCC_HOLD_START;
            end else if (hold_q != SCC_HOLD_NONE) begin
                hold_q <= hold_q - SCC_HOLD_START;
            end
        end
    end

    // Bus control outputs and returned data, all registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_start_q <= 1'b1;
            brdy_q <= 1'b1;
            cacheable_to_cpu_n_q <= 1'b0;
            dout_q <= '0;
            pout_q <= '0;
            oe_n_q <= 1'b1;
        end else if (ce) begin
            if (cache_reset || backoff) begin
                // Idle levels and a floating data bus
                mem_start_q <= 1'b1;
                brdy_q <= 1'b1;
                cacheable_to_cpu_n_q <= 1'b0;
                oe_n_q <= 1'b1;
            end else begin
                case (state_q)
                    SCC_IDLE: begin
                        cacheable_to_cpu_n_q <= 1'b0;
                        if (mem_cyc && !write_read && arr.lk_hit) begin
                            // Zero-wait hit: first word in the first second state
                            brdy_q <= 1'b0;
                            cacheable_to_cpu_n_q <= 1'b1;
                            dout_q <= arr.rd_data;
                            pout_q <= arr.rd_par;
                            oe_n_q <= 1'b0;
                        end else if (mem_cyc) begin
                            // Read miss or any write goes to memory
                            mem_start_q <= 1'b0;
                            cacheable_to_cpu_n_q <= 1'b1;
                        end
                    end
                    SCC_RD_HIT: begin
                        if (!burst_final_n) begin
                            brdy_q <= 1'b1;
                            oe_n_q <= 1'b1;
                            cacheable_to_cpu_n_q <= 1'b0;
                        end else begin
                            cacheable_to_cpu_n_q <= 1'b0;
                            dout_q <= arr.rd_data;
                            pout_q <= arr.rd_par;
                        end
                    end
                    SCC_RD_MISS, SCC_WRITE: begin
                        if (ready) begin
                            // Memory answered, its start request is done
                            mem_start_q <= 1'b1;
                        end
                        if (state_q == SCC_WRITE ? ready : fill_end) begin
                            cacheable_to_cpu_n_q <= 1'b0;
                        end
                    end
                    default: begin
                        mem_start_q <= 1'b1;
                        brdy_q <= 1'b1;
                        oe_n_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Static module identification; the strap pin is deliberately unused
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            present_q <= 1'b0;
            id_q <= SCC_ID_THIS;
        end else if (ce) begin
            present_q <= 1'b0;
            id_q <= SCC_ID_THIS;
        end
    end

    assign mem_start_n = mem_start_q;
    assign cache_burst_ready_out_n = brdy_q;
    assign cacheable_to_cpu_n = cacheable_to_cpu_n_q;
    assign data_out = dout_q;
    assign byte_parity_out = pout_q;
    assign data_oe_n = oe_n_q;
    assign module_present_n = present_q;
    assign size_id_bit0 = id_q[0];
    assign size_id_bit1 = id_q[1];

endmodule

// *** bench/scc_cache_ctrl_sva.sv ***
// Port checker of the cache controller, attached by bind.
// Assumes one bus clock and the async active-low reset.
`timescale 1ns/100ps
module scc_cache_ctrl_sva import scc_pkg::*; (
    input wire logic clk, rst_n, cache_reset, cycle_start_strobe_n, snoop_address_strobe_n,
    input wire logic chip_select_n, mem_io, write_read, data_control, burst_final_n,
    input wire logic bus_backoff_n, mem_start_n, cache_burst_ready_out_n, cacheable_to_cpu_n,
    input wire logic data_oe_n, module_present_n, size_id_bit0, size_id_bit1
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Idle outputs, so a start seen here must begin a fresh cycle
    wire idle = mem_start_n & cache_burst_ready_out_n & !cacheable_to_cpu_n & !cache_reset;
    wire go = !cycle_start_strobe_n & bus_backoff_n & idle;
    wire mem = go & !chip_select_n & snoop_address_strobe_n & mem_io;
    present_low_a: assert property (!module_present_n) else $error("presence");
    size_code_a: assert property ({size_id_bit1, size_id_bit0} == SCC_ID_THIS) else $error("id");
    select_gate_a: assert property (go && chip_select_n |=> idle) else $error("no select");
    io_skip_a: assert property (go && !mem_io && data_control |=> idle) else $error("io");
    write_go_a: assert property (mem && write_read |=> !mem_start_n) else $error("write");
    read_go_a: assert property (mem && !write_read |=> mem_start_n != cache_burst_ready_out_n) else $error("read");
    snoop_wins_a: assert property (go && !chip_select_n && !snoop_address_strobe_n |=> idle) else $error("snoop");
    backoff_idle_a: assert property (!bus_backoff_n |=> data_oe_n && idle) else $error("backoff");
    burst_end_a: assert property (!cache_burst_ready_out_n && !burst_final_n |=> $rose(cache_burst_ready_out_n)) else $error("last");
    miss_flag_a: assert property (!mem_start_n |-> cacheable_to_cpu_n) else $error("enable");
endmodule

// *** bench/scc_mem_model.sv ***
// Memory system model: answers each memory start with ready words.
// Assumes one request at a time; word count and wait set by the bench.
`timescale 1ns/100ps
module scc_mem_model (
    input wire logic clk, rst_n, mem_start_n, cach_en,
    input wire logic [2:0] words,
    input wire logic [1:0] lat,
    input wire logic [31:0] base,
    output logic brdy_n, srdy_n, last_n, cach_n,
    output logic [31:0] data
);
    logic busy_q;
    logic [2:0] left_q = 3'h0;
    logic [1:0] wait_q = 2'h0;
    wire on = busy_q && wait_q == 2'h0;
    assign brdy_n = !(on && words != 3'h1);
    assign srdy_n = !(on && words == 3'h1);
    assign last_n = !(on && left_q == 3'h1);
    // Cacheable from the wait cycles on, so it leads the first word
    assign cach_n = !(busy_q && cach_en);
    // Released bus shows the inverse so a stale word never matches
    assign data = on ? base ^ 32'(left_q) : ~(base ^ 32'(left_q));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) busy_q <= 1'b0;
        else if (!busy_q) busy_q <= !mem_start_n;
        else if (on && left_q == 3'h1) busy_q <= 1'b0;
    end
    always_ff @(posedge clk) begin
        if (!busy_q) left_q <= words;
        else if (on) left_q <= left_q - 3'h1;
        wait_q <= !busy_q ? lat : (wait_q != 2'h0 ? wait_q - 2'h1 : 2'h0);
    end
endmodule

// *** bench/scc_cache_ctrl_tb.sv ***
// Bench of the cache controller: processor driver plus memory model.
// Assumes the checker is bound to the controller below.
`timescale 1ns/100ps
module scc_cache_ctrl_tb;
    import scc_pkg::*;
    logic clk = 0, rst_n = 0, ads_n = 1, snp_n = 1, cs_n = 1, mio = 1, wr = 0, dc = 1;
    logic bo_n = 1, crst = 0, fl_n = 1, wp = 0, cen = 1, last_q = 1;
    logic [3:0] be_n = 4'hF;
    logic [31:2] addr = '0, a;
    logic [31:0] base = '0, w0, w1, seed = 32'hCFDA, rx[$];
    logic [2:0] words = 3'h4;
    logic [1:0] lat = 2'h1, k = 2'h0;
    wire [31:0] dout, din;
    wire [3:0] pout;
    logic [3:0] p0;
    wire ms_n, bro_n, brdy_n, srdy_n, ml_n, cach_n;
    int err_total = 0, n_checks = 0, ms = 0, cyc = 0;
    scc_cache_ctrl dut (.clk, .rst_n, .ce(1'b1), .cache_reset(crst), .cycle_start_strobe_n(ads_n),
        .snoop_address_strobe_n(snp_n), .chip_select_n(cs_n), .mem_io(mio), .write_read(wr),
        .data_control(dc), .byte_lane_enable_n(be_n), .cpu_addr(addr), .data_in(din),
        .byte_parity_in(din[3:0]), .mem_burst_ready_in_n(brdy_n), .mem_single_ready_in_n(srdy_n),
        .burst_final_n(last_q & ml_n), .bus_backoff_n(bo_n), .system_cacheable_n(cach_n),
        .write_protect(wp), .flush_n(fl_n), .protect_strap_unused(1'b0), .mem_start_n(ms_n),
        .cache_burst_ready_out_n(bro_n), .cacheable_to_cpu_n(), .data_out(dout),
        .byte_parity_out(pout), .data_oe_n(), .module_present_n(),
        .size_id_bit0(), .size_id_bit1());
    scc_mem_model mem (.clk, .rst_n, .mem_start_n(ms_n), .cach_en(cen), .words, .lat, .base,
        .brdy_n, .srdy_n, .last_n(ml_n), .cach_n, .data(din));
    initial forever #10 clk = ~clk;
    // Processor side: collect burst words, drop burst last on the fourth
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ms_n === 1'b0) ms <= ms + 1;
        if (bro_n === 1'b0) rx.push_back(dout);
        if (bro_n === 1'b0 && k == 2'h0) p0 <= pout;
        k <= (bro_n === 1'b0) ? k + 2'h1 : 2'h0;
        last_q <= !(bro_n === 1'b0 && k == 2'h2);
        if (cyc == 3000) begin
            err_total++;
            finish_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Fill word n as the model hands it out
    function automatic logic [31:0] fw(input int n);
        return base ^ 32'(4 - n);
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One bus cycle: start strobe, optional snoop with it, optional backoff after
    task automatic go(input logic [31:2] aa, input logic w, m, c, d, input logic [3:0] be,
        input logic s, b);
        @(posedge clk);
        ms = 0;
        rx = {};
        {addr, wr, mio, cs_n, dc, be_n, ads_n, snp_n, words} <= {aa, w, m, !c, d, be, 1'b0, !s,
            w ? 3'h1 : 3'h4};
        @(posedge clk);
        {ads_n, snp_n, bo_n} <= {2'b11, !b};
        @(posedge clk);
        bo_n <= 1'b1;
        repeat (12) @(posedge clk);
        lat <= 2'h1 + 2'(rnd() % 3);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // Fill, leave the line alone in case 0 and disturb it one way in each later case, then read it again
        for (int i = 0; i < 7; i++) begin
            a = 30'(rnd());
            {base, cen, wp} <= {rnd(), i != 5, i == 6};
            go(a, 0, 1, 1, 1, 4'hF, 0, 0);
            chk("fill start", 1, ms != 0);
            {cen, wp, fl_n, crst} <= {2'b10, i != 2, i == 4};
            @(posedge clk);
            {fl_n, crst} <= 2'b10;
            if (i == 1) go(a, 0, 1, 1, 1, 4'hF, 1, 0);
            if (i == 3) go(a, 1, 0, 1, 0, SCC_FLUSH_BE_N, 0, 0);
            go(a, 0, 1, 1, 1, 4'hF, 0, 0);
            chk("hit", i == 0, ms == 0);
            for (int n = 0; n < 4 && i == 0; n++) chk("burst word", fw(n), rx[n]);
            $display("case %0d done", i);
        end
        go(a, 0, 1, 1, 1, 4'hF, 0, 0);
        w0 = fw(0);
        base <= rnd();
        go(a, 1, 1, 1, 1, 4'hE, 0, 0);
        chk("write start", 1, ms != 0);
        w1 = fw(3);
        go(a, 0, 1, 1, 1, 4'hF, 0, 0);
        chk("write hit", {w0[31:8], w1[7:0]}, rx[0]);
        chk("write parity", {w0[3:1], w1[0]}, p0);
        $display("write test done");
        go(a, 0, 1, 0, 1, 4'hF, 0, 0);
        chk("no select", 0, 32'(ms + rx.size()));
        go(a, 0, 0, 1, 1, 4'hF, 0, 0);
        chk("io cycle", 0, 32'(ms + rx.size()));
        go(a, 0, 1, 1, 1, 4'hF, 0, 1);
        chk("backoff words", 1, 32'(rx.size()));
        $display("select, io and backoff tests done");
        finish_test();
    end
endmodule
bind scc_cache_ctrl scc_cache_ctrl_sva chk (.*);
